// >>> bench/piage_host.sv
module piage_host (
   // Clock
   input wire logic core_clk_i,
   // Link pins, host side
   input wire logic sda_i,
   input wire logic [4:0] strap_i,
   output logic scl_o,
   output logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Phases of 8 core clocks, twice the slave's minimum
   task automatic half();
      repeat (8) @(posedge core_clk_i);
      #2;
   endtask
   // Also serves as repeated start from a low clock
   task automatic start();
      sda_low_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_low_o = 1'b1;
      half();
      scl_o = 1'b0;
      half();
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      sda_low_o = 1'b0;
      half();
   endtask
   // Ninth bit released: slave acks a write, host nacks a read
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic [8:0] sh;
      sh = {d, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         sda_low_o = !sh[i];
         half();
         scl_o = 1'b1;
         half();
         sh[i] = sda_i;
         scl_o = 1'b0;
         half();
      end
      q = sh[8:1];
      ack = !sh[0];
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start();
      xfer({piage_pkg::I2C_ADDR_HI, strap_i, 1'b0}, q, k0);
      xfer(a, q, k1);
      xfer(d, q, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
      logic k0, k1, k2, nak;
      start();
      xfer({piage_pkg::I2C_ADDR_HI, strap_i, 1'b0}, q, k0);
      xfer(a, q, k1);
      start();
      xfer({piage_pkg::I2C_ADDR_HI, strap_i, 1'b1}, q, k2);
      xfer(8'hFF, q, nak);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule

// >>> bench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, host_low, sda_oe, sda_drv, hold_off, int_n, det, ok;
   logic [3:0] leaky, fet_bad;
   logic [31:0] ev;
   logic [7:0] q, m;
   piage_pkg::piage_fault_in_t flt;
   // Open drain: the device pulls low only while enabled and driving zero
   wire sda = !(host_low || (sda_oe && !sda_drv));
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   piage_host host (.core_clk_i(clk), .sda_i(sda), .strap_i(5'h0D), .scl_o(scl),
      .sda_low_o(host_low));
   piage_top #(.REFRESH_CYCLES(50)) uut (.core_clk_i(clk), .nrst_i(nrst), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe), .addr_strap_i(5'h0D),
      .auto_strap_i(1'b1), .fault_i(flt), .port_event_set_i(ev), .det_cycle_start_i(det),
      .port_leaky_i(leaky), .port_fet_bad_o(fet_bad), .ports_hold_off_o(hold_off),
      .int_n_o(int_n));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         $display("BAD cycles exp below %0d got %0d", 90000, cycles);
         miscompares++;
         stop_test();
      end
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic rc(logic [7:0] a, logic [7:0] e);
      host.rd(a, q, ok);
      chk("ack", 8'h01, {7'h0, ok});
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic wc(logic [7:0] a, logic [7:0] d);
      host.wr(a, d, ok);
      chk("ack", 8'h01, {7'h0, ok});
   endtask
   task automatic wt();
      repeat (10) @(posedge clk);
      #2;
   endtask
   task automatic pulse(int i);
      @(posedge clk);
      #2;
      ev[i] = 1'b1;
      @(posedge clk);
      #2;
      ev = '0;
      wt();
   endtask
   task automatic t_regs();
      rc(8'h00, 8'h20);
      rc(8'h01, 8'h80);
      rc(8'h05, 8'h35);
      wc(8'h00, 8'hFF);
      rc(8'h00, 8'h20);
      rc(8'h07, 8'h00);
      chk("int_n", 8'h01, {7'h0, int_n});
      rc(8'h03, 8'h20);
      rc(8'h02, 8'h00);
      rc(8'h00, 8'h00);
      wc(8'h0A, 8'h16);
      rc(8'h0A, 8'h16);
      $display("test regs done");
   endtask
   // Only global registers are written, never the per-port ones
   task automatic t_mask();
      for (int b = 0; b < 8; b++) begin
         m = 8'h01 << ((b == 7) ? 6 : b);
         wc(8'h01, ~m & 8'h7F);
         pulse(b);
         chk("int_n blocked", 8'h01, {7'h0, int_n});
         rc(8'h00, 8'h01);
         wc(8'h01, m);
         chk("int_n open", 8'h00, {7'h0, int_n});
         rc(8'h11, 8'h01 << b);
         rc(8'h00, 8'h00);
         chk("int_n clr", 8'h01, {7'h0, int_n});
      end
      $display("test mask done");
   endtask
   task automatic t_pb();
      wc(8'h01, 8'h02);
      pulse(17);
      chk("int_n", 8'h00, {7'h0, int_n});
      wc(8'h0B, 8'h40);
      chk("int_n pinclr", 8'h01, {7'h0, int_n});
      rc(8'h00, 8'h04);
      wc(8'h0B, 8'h80);
      rc(8'h00, 8'h00);
      rc(8'h30, 8'h02);
      rc(8'h31, 8'h02);
      $display("test push-button done");
   endtask
   task automatic t_fault();
      wc(8'h01, 8'h80);
      flt.overtemp = 1'b1;
      wt();
      chk("int_n ot", 8'h00, {7'h0, int_n});
      rc(8'h00, 8'h80);
      rc(8'h03, 8'h80);
      rc(8'h02, 8'h80);
      flt.overtemp = 1'b0;
      rc(8'h03, 8'h80);
      rc(8'h02, 8'h00);
      chk("int_n", 8'h01, {7'h0, int_n});
      flt.logic_supply_low = 1'b1;
      wt();
      chk("hold lo3", 8'h01, {7'h0, hold_off});
      flt.logic_supply_low = 1'b0;
      wt();
      chk("hold ok3", 8'h00, {7'h0, hold_off});
      rc(8'h02, 8'h20);
      rc(8'h03, 8'h20);
      flt.main_above_hi = 1'b0;
      flt.main_below_lo = 1'b1;
      wt();
      flt.main_below_lo = 1'b0;
      wt();
      chk("hold hyst", 8'h01, {7'h0, hold_off});
      flt.main_above_hi = 1'b1;
      flt.thermal_all_off = 1'b1;
      wt();
      flt.thermal_all_off = 1'b0;
      wt();
      chk("hold ok48", 8'h00, {7'h0, hold_off});
      rc(8'h00, 8'h10);
      rc(8'h03, 8'h18);
      leaky = 4'b0100;
      @(posedge clk);
      #2;
      det = 1'b1;
      @(posedge clk);
      #2;
      det = 1'b0;
      leaky = 4'b0000;
      wt();
      chk("fet_bad", 8'h04, {4'h0, fet_bad});
      rc(8'h03, 8'h40);
      rc(8'h02, 8'h00);
      $display("test faults done");
   endtask
   task automatic t_off();
      wc(8'h01, 8'hFF);
      wc(8'h0A, 8'h96);
      pulse(25);
      chk("int_n off", 8'h01, {7'h0, int_n});
      rc(8'h41, 8'h02);
      $display("test disable done");
   endtask
   initial begin
      flt = '0;
      flt.main_above_hi = 1'b1;
      ev = '0;
      det = 1'b0;
      leaky = '0;
      repeat (5) @(posedge clk);
      #2;
      nrst = 1'b1;
      wt();
      t_regs();
      t_mask();
      t_pb();
      t_fault();
      t_off();
      stop_test();
   end
endmodule

// >>> src/piage_pkg.sv
package piage_pkg;
   // Register map, byte addresses on the serial link
   localparam logic [7:0] ADDR_SUMMARY = 8'h00;
   localparam logic [7:0] ADDR_MASK = 8'h01;
   localparam logic [7:0] ADDR_FAULT = 8'h02;
   localparam logic [7:0] ADDR_FAULT_COR = 8'h03;
   localparam logic [7:0] ADDR_STATUS = 8'h05;
   localparam logic [7:0] ADDR_CONFIG = 8'h0A;
   localparam logic [7:0] ADDR_GLOBAL_PUSH_BUTTON = 8'h0B;
   // Per-port groups sit at 0x10, 0x20, 0x30, 0x40
   localparam logic [3:0] PORT_EV_OFS = 4'h0;
   localparam logic [3:0] PORT_EV_COR_OFS = 4'h1;
   localparam int NPORT = 4;
   // Reset values
   localparam logic [7:0] RST_SUMMARY = 8'h20;
   localparam logic [7:0] RST_MASK = 8'h80;
   localparam logic [7:0] RST_FAULT = 8'h20;
   localparam logic [7:0] RST_CONFIG = 8'h96;
   // Field positions
   localparam int FB_OVERTEMP = 7;
   localparam int FB_FETBAD = 6;
   localparam int FB_LOGIC_LOCK = 5;
   localparam int FB_MAIN_LOCK = 4;
   localparam int FB_TSD = 3;
   localparam int MB_GLOBAL = 7;
   localparam int MB_IFAULT = 6;
   localparam int EB_TLIM = 7;
   localparam int EB_TCUT = 6;
   localparam int CB_INT_DISABLE = 7;
   localparam int PB_INTCLR = 7;
   localparam int PB_PINCLR = 6;
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int REFRESH_MS = 2;
   localparam int REFRESH_CYCLES = REFRESH_MS * (CLK_HZ / 1000);
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   // Upper two bits of the 7-bit slave address; arbitrary neutral value
   localparam logic [1:0] I2C_ADDR_HI = 2'h1;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_WACK, ST_WDATA, ST_RDATA, ST_HACK
   } piage_i2c_st_t;

   typedef struct packed {
      logic overtemp;
      logic logic_supply_low;
      logic main_below_lo;
      logic main_above_hi;
      logic thermal_all_off;
   } piage_fault_in_t;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } piage_wr_t;
endpackage

// >>> src/piage_port_events.sv
module piage_port_events #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Event pulses from the port sequencer, clear-on-read strobe
   input wire logic [W-1:0] set_i,
   input wire logic cor_clear_i,
   // Latched event bits
   output logic [W-1:0] ev_o
);
   logic [W-1:0] next_ev;

   // A set arriving with the clear survives it
   assign next_ev = (cor_clear_i ? '0 : ev_o) | set_i;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ev_o <= '0;
      end else begin
         ev_o <= next_ev;
      end
   end
endmodule

// >>> src/piage_sync2.sv
module piage_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Asynchronous level in, synchronous level out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] stage1;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// >>> src/piage_top.sv
// Contract
// - High summary bits mirror overtemp, bad transistor, logic and main supply lockout.
// - Interrupt pin goes low when a summary group is set and its mask is one.
// - A summary bit clears only after its source clears, or on a bit-7 global push-button write.
// - Writing bit 7 of global push-button clears all summary bits except those whose source rises in the same cycle.
// - Writing bit 6 of global push-button deasserts the pin, sources untouched.
// - Mask only affects the pin; summary and events set regardless.
// - Mask one lets an event type reach the pin; zero blocks it.
// - Mask bit 6 gates cutoff and limit timeout events of all ports.
// - Mask bit 5 gates start-fault events of all ports.
// - Mask bit 1 gates power-good events of all ports.
// - Mask bit 0 gates power-enabled events of all ports.
// - Clear-on-read alias reads as fault flags; reading clears both.
// - Overtemp flag sets again within milliseconds while overtemp persists.
// - Bad-transistor flag sets on any leaky transistor, held until alias read.
// - Leaky test at detection start updates each port's bad-transistor status.
// - Logic supply lockout latches on good-to-bad only, held until alias read.
// - Ports held powered down while logic supply is below threshold.
// - Main lockout latches good-to-bad, with hysteresis between low and high threshold.
// - Ports held powered down until main supply exceeds upper threshold.
// - Thermal shutdown flag sets when all powered ports shut down, held until alias read.
// - Port event bits latch and clear only on their clear-on-read register.
// - Interrupt disable bit keeps the pin high whatever events and mask.
module piage_top #(
   parameter int REFRESH_CYCLES = piage_pkg::REFRESH_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Serial register link, separate data in and open-drain data out
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Address and mode straps
   input wire logic [4:0] addr_strap_i,
   input wire logic auto_strap_i,
   // Analog comparators and thermal monitor
   input wire piage_pkg::piage_fault_in_t fault_i,
   // Port sequencer, same clock
   input wire logic [piage_pkg::NPORT*8-1:0] port_event_set_i,
   input wire logic det_cycle_start_i,
   input wire logic [piage_pkg::NPORT-1:0] port_leaky_i,
   output logic [piage_pkg::NPORT-1:0] port_fet_bad_o,
   output logic ports_hold_off_o,
   // Host interrupt
   output logic int_n_o
);
   localparam int NP = piage_pkg::NPORT;
   localparam int RW = $clog2(REFRESH_CYCLES + 1);

   piage_pkg::piage_fault_in_t flt_s;
   piage_pkg::piage_i2c_st_t state;
   piage_pkg::piage_wr_t wr;
   logic scl_s, sda_s, scl_q, sda_q, auto_s;
   logic [4:0] addr_s, addr_cap;
   logic auto_cap;
   logic [1:0] strap_cnt;
   logic [7:0] shift, tx, ptr, rd_data;
   logic [3:0] cnt;
   logic rw_bit, nack, rd_pulse;
   logic [7:0] mask, config_reg, flags, summary, src_prev;
   logic overtemp_q, logic_low_q, main_lock, main_lock_q, thermal_q;
   logic suppress;
   logic [RW-1:0] refresh_cnt;
   logic [NP-1:0][7:0] ev;
   logic [NP-1:0] port_cor;

   piage_sync2 #(.W(2)) u_link_sync (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .async_i({scl_i, sda_i}),
      .sync_o({scl_s, sda_s})
   );

   piage_sync2 #(.W(11)) u_pin_sync (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .async_i({fault_i, addr_strap_i, auto_strap_i}),
      .sync_o({flt_s, addr_s, auto_s})
   );

   // Per-port latched events
   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         assign port_cor[p] = rd_pulse && (ptr[7:4] == 4'(p + 1))
            && (ptr[3:0] == piage_pkg::PORT_EV_COR_OFS);
         piage_port_events #(.W(8)) u_events (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .set_i(port_event_set_i[p*8 +: 8]),
            .cor_clear_i(port_cor[p]),
            .ev_o(ev[p])
         );
      end
   endgenerate

   // Serial link edge and condition detection
   wire scl_rise = scl_s && !scl_q;
   wire scl_fall = !scl_s && scl_q;
   wire start_cond = scl_s && scl_q && sda_q && !sda_s;
   wire stop_cond = scl_s && scl_q && !sda_q && sda_s;
   wire [6:0] my_addr = {piage_pkg::I2C_ADDR_HI, addr_cap};
   wire byte_in = (cnt == 4'h8);

   // Read selection
   wire [1:0] port_idx = 2'(ptr[5:4] - 2'h1);
   wire port_hit = (ptr[7:4] >= 4'h1) && (ptr[7:4] <= 4'(NP))
      && ((ptr[3:0] == piage_pkg::PORT_EV_OFS) || (ptr[3:0] == piage_pkg::PORT_EV_COR_OFS));
   wire [7:0] status_val = {1'b0, addr_cap, 1'b0, auto_cap};
   assign rd_data = port_hit ? ev[port_idx] :
      (ptr == piage_pkg::ADDR_SUMMARY) ? summary :
      (ptr == piage_pkg::ADDR_MASK) ? mask :
      (ptr == piage_pkg::ADDR_FAULT) ? flags :
      (ptr == piage_pkg::ADDR_FAULT_COR) ? flags :
      (ptr == piage_pkg::ADDR_STATUS) ? status_val :
      (ptr == piage_pkg::ADDR_CONFIG) ? config_reg : 8'h00;

   // Link slave: clocks bytes on the host's clock edges, answers from the pointer
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state <= piage_pkg::ST_IDLE;
         shift <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         cnt <= 4'h0;
         rw_bit <= 1'b0;
         nack <= 1'b0;
         sda_oe_o <= 1'b0;
         rd_pulse <= 1'b0;
         wr <= '0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         rd_pulse <= 1'b0;
         wr.en <= 1'b0;
         if (start_cond) begin
            state <= piage_pkg::ST_ADDR;
            cnt <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop_cond) begin
            state <= piage_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
         end else if (scl_rise) begin
            if (state == piage_pkg::ST_HACK) begin
               nack <= sda_s;
            end else if (state == piage_pkg::ST_ADDR || state == piage_pkg::ST_REG
                         || state == piage_pkg::ST_WDATA) begin
               shift <= {shift[6:0], sda_s};
               cnt <= cnt + 4'h1;
            end
         end else if (scl_fall) begin
            case (state)
               piage_pkg::ST_ADDR: if (byte_in) begin
                  if (shift[7:1] == my_addr) begin
                     rw_bit <= shift[0];
                     sda_oe_o <= 1'b1;
                     state <= piage_pkg::ST_AACK;
                  end else begin
                     state <= piage_pkg::ST_IDLE;
                  end
               end
               piage_pkg::ST_AACK: begin
                  cnt <= 4'h0;
                  if (rw_bit) begin
                     tx <= rd_data;
                     rd_pulse <= 1'b1;
                     sda_oe_o <= !rd_data[7];
                     state <= piage_pkg::ST_RDATA;
                  end else begin
                     sda_oe_o <= 1'b0;
                     state <= piage_pkg::ST_REG;
                  end
               end
               piage_pkg::ST_REG: if (byte_in) begin
                  ptr <= shift;
                  sda_oe_o <= 1'b1;
                  state <= piage_pkg::ST_WACK;
               end
               piage_pkg::ST_WACK: begin
                  cnt <= 4'h0;
                  sda_oe_o <= 1'b0;
                  state <= piage_pkg::ST_WDATA;
               end
               piage_pkg::ST_WDATA: if (byte_in) begin
                  wr <= '{en: 1'b1, addr: ptr, data: shift};
                  ptr <= ptr + 8'h01;
                  sda_oe_o <= 1'b1;
                  state <= piage_pkg::ST_WACK;
               end
               piage_pkg::ST_RDATA: begin
                  if (cnt == 4'h7) begin
                     ptr <= ptr + 8'h01;
                     sda_oe_o <= 1'b0;
                     state <= piage_pkg::ST_HACK;
                  end else begin
                     tx <= {tx[6:0], 1'b0};
                     sda_oe_o <= !tx[6];
                     cnt <= cnt + 4'h1;
                  end
               end
               piage_pkg::ST_HACK: begin
                  cnt <= 4'h0;
                  if (nack) begin
                     state <= piage_pkg::ST_IDLE;
                  end else begin
                     tx <= rd_data;
                     rd_pulse <= 1'b1;
                     sda_oe_o <= !rd_data[7];
                     state <= piage_pkg::ST_RDATA;
                  end
               end
               default: state <= piage_pkg::ST_IDLE;
            endcase
         end
      end
   end

   assign sda_o = 1'b0;

   // Straps are caught once, after the synchronisers have filled
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strap_cnt <= 2'h0;
         addr_cap <= 5'h00;
         auto_cap <= 1'b0;
      end else if (strap_cnt != piage_pkg::STRAP_WAIT) begin
         strap_cnt <= strap_cnt + 2'h1;
         addr_cap <= addr_s;
         auto_cap <= auto_s;
      end
   end

   // Register writes
   wire wr_mask = wr.en && (wr.addr == piage_pkg::ADDR_MASK);
   wire wr_cfg = wr.en && (wr.addr == piage_pkg::ADDR_CONFIG);
   wire wr_pb = wr.en && (wr.addr == piage_pkg::ADDR_GLOBAL_PUSH_BUTTON);
   wire intclr = wr_pb && wr.data[piage_pkg::PB_INTCLR];
   wire pinclr = wr_pb && wr.data[piage_pkg::PB_PINCLR];
   wire fault_cor = rd_pulse && (ptr == piage_pkg::ADDR_FAULT_COR);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask <= piage_pkg::RST_MASK;
         config_reg <= piage_pkg::RST_CONFIG;
      end else begin
         if (wr_mask) mask <= wr.data;
         if (wr_cfg) config_reg <= wr.data;
      end
   end

   // Supply and thermal monitors
   wire refresh_tick = (refresh_cnt == RW'(REFRESH_CYCLES - 1));
   wire [NP-1:0] leaky_now = det_cycle_start_i ? port_leaky_i : 4'h0;
   logic [7:0] flag_set;
   always_comb begin
      flag_set = 8'h00;
      flag_set[piage_pkg::FB_OVERTEMP] = (flt_s.overtemp && !overtemp_q)
         || (flt_s.overtemp && refresh_tick);
      flag_set[piage_pkg::FB_FETBAD] = |leaky_now;
      flag_set[piage_pkg::FB_LOGIC_LOCK] = flt_s.logic_supply_low && !logic_low_q;
      flag_set[piage_pkg::FB_MAIN_LOCK] = main_lock && !main_lock_q;
      flag_set[piage_pkg::FB_TSD] = flt_s.thermal_all_off && !thermal_q;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags <= piage_pkg::RST_FAULT;
         overtemp_q <= 1'b0;
         logic_low_q <= 1'b0;
         thermal_q <= 1'b0;
         main_lock <= 1'b1;
         main_lock_q <= 1'b1;
         refresh_cnt <= '0;
         port_fet_bad_o <= '0;
         ports_hold_off_o <= 1'b1;
      end else begin
         // Set wins over the momentary clear of an alias read
         flags <= (fault_cor ? 8'h00 : flags) | flag_set;
         overtemp_q <= flt_s.overtemp;
         logic_low_q <= flt_s.logic_supply_low;
         thermal_q <= flt_s.thermal_all_off;
         main_lock_q <= main_lock;
         if (flt_s.main_below_lo) main_lock <= 1'b1;
         else if (flt_s.main_above_hi) main_lock <= 1'b0;
         refresh_cnt <= refresh_tick ? '0 : refresh_cnt + RW'(1);
         if (det_cycle_start_i) port_fet_bad_o <= port_leaky_i;
         ports_hold_off_o <= flt_s.logic_supply_low || main_lock;
      end
   end

   // Summary: follows its sources, newly raised sources set it again
   logic [7:0] sum_src, rise;
   generate
      for (p = 0; p < NP; p++) begin : g_src
         assign sum_src[p] = |ev[p];
      end
   endgenerate
   assign sum_src[7:4] = flags[7:4];
   assign rise = sum_src & ~src_prev;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         summary <= piage_pkg::RST_SUMMARY;
         src_prev <= piage_pkg::RST_SUMMARY;
      end else begin
         src_prev <= sum_src;
         summary <= ((intclr ? 8'h00 : summary) & sum_src) | rise;
      end
   end

   // Pin gating per event group; summary and events ignore the mask
   logic [7:0] grp, ev_gate;
   always_comb begin
      ev_gate = 8'h00;
      for (int i = 0; i < NP; i++) begin
         ev_gate = ev_gate | (summary[i] ? ev[i] : 8'h00);
      end
      grp = ev_gate;
      grp[piage_pkg::MB_IFAULT] = ev_gate[piage_pkg::EB_TLIM]
         || ev_gate[piage_pkg::EB_TCUT];
      grp[piage_pkg::MB_GLOBAL] = |summary[7:4];
   end
   wire int_want = |(grp & mask);
   wire int_dis = config_reg[piage_pkg::CB_INT_DISABLE];

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         suppress <= 1'b0;
         int_n_o <= 1'b1;
      end else begin
         // A fresh event re-arms the pin after a pin clear
         suppress <= (|rise) ? 1'b0 : (pinclr ? 1'b1 : suppress);
         int_n_o <= !(int_want && !int_dis && !(pinclr || (suppress && !(|rise))));
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   a_summary_holds: assert property (!intclr |=>
      (summary & $past(summary & sum_src)) == $past(summary & sum_src))
      else $error("summary bit cleared while source held");
   a_summary_rise: assert property (|rise |=> (summary & $past(rise)) == $past(rise))
      else $error("raised source missing from summary");
   a_pin_asserts: assert property (
      (int_want && !int_dis && !suppress && !pinclr) |=> !int_n_o)
      else $error("interrupt pin not driven low");
   a_intclr_wipes: assert property (intclr |=> (summary & ~$past(rise)) == 8'h00)
      else $error("summary not cleared by intclr");
   a_pinclr_release: assert property ((pinclr && !(|rise)) |=>
      int_n_o && flags == $past(flags | flag_set))
      else $error("pin clear failed or touched sources");
   a_disable_high: assert property (int_dis |=> int_n_o)
      else $error("interrupt pin low while disabled");
   a_cor_clears: assert property ((fault_cor && flag_set == 8'h00) |=> flags == 8'h00)
      else $error("fault flags not cleared by alias read");
   a_fetbad_sets: assert property ((det_cycle_start_i && |port_leaky_i) |=>
      flags[piage_pkg::FB_FETBAD] && port_fet_bad_o == $past(port_leaky_i))
      else $error("bad transistor not flagged");
   a_main_hyst: assert property ((main_lock && !flt_s.main_above_hi) |=> main_lock)
      else $error("main lockout left below upper threshold");
   a_ports_held: assert property ((flt_s.logic_supply_low || main_lock) |=>
      ports_hold_off_o)
      else $error("ports released during lockout");
endmodule
